// file: pmi_cmd_slave.sv
// two-wire command slave of a power module: decodes 16-bit command words,
// stores settings and answers reads with upper/lower bytes or byte strings
// assumes scl_i and sda_i are synchronous to ref_clk and much slower than it
//
// Operation
// - command is 16 bits, upper byte first
// - payload sits in command bits 9 to 0
// - 8-bit values use payload bits 7 to 0
// - register select lies in bits 14 to 10
// - select bit zero writes payload to register
// - select bit one returns register on next read
// - fixed select codes for each register
// - identity writes are production only; protect on and off commands are taken whatever the protect state
// - write: start, address, two bytes, stop
// - acknowledge address and every received byte
// - two-byte read sends upper then lower byte
// - string read sends every byte of item
// - broadcast addresses 0 and 1 are write only
`timescale 1ns/1ps
module pmi_cmd_slave
#(
   parameter int STR_LEN = pmi_pkg::PMI_STR_LEN_DEF,
   parameter logic [pmi_pkg::PMI_VAL_W-1:0] TARGET_RST = pmi_pkg::PMI_TARGET_RST
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [pmi_pkg::PMI_VAL_W-1:0] bus_target_id,
   output logic [pmi_pkg::PMI_VAL_W-1:0] overvolt_trip_setting,
   output logic [pmi_pkg::PMI_VAL_W-1:0] output_volt_setting,
   output logic [pmi_pkg::PMI_VAL_W-1:0] current_limit_setting,
   input wire logic [pmi_pkg::PMI_VAL_W-1:0] temperature_reading,
   input wire logic [pmi_pkg::PMI_VAL_W-1:0] output_volt_reading,
   input wire logic [pmi_pkg::PMI_VAL_W-1:0] current_reading,
   output logic soft_restart,
   output logic protect_on
);
   import pmi_pkg::*;

   localparam int MEM_N = 4 * STR_LEN;
   localparam int IW = $clog2(MEM_N);

   // ---------------------------------------------------------------
   // line sampling and bus conditions
   // ---------------------------------------------------------------
   logic scl_q;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   logic start_det;
   logic stop_det;

   pmi_edge u_scl_edge
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .line_i(scl_i),
      .prev_q(scl_q),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   pmi_edge u_sda_edge
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .line_i(sda_i),
      .prev_q(),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   // data may only move while the clock is low, so an sda edge under a
   // steady high clock marks start or stop
   assign start_det = sda_fall & scl_q & scl_i;
   assign stop_det = sda_rise & scl_q & scl_i;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pmi_state_t state_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] shreg_q;
   logic [7:0] tx_q;
   logic [7:0] byte_cnt_q;
   logic rw_q;
   logic pend_q;
   logic sda_oe_q;
   logic [7:0] cmd_hi_q;
   logic [PMI_CMD_W-1:0] cmd_word_q;
   logic cmd_stb_q;
   logic [7:0] dat_q;
   logic [7:0] dat_idx_q;
   logic dat_stb_q;

   logic [PMI_VAL_W-1:0] target_q;
   logic [PMI_VAL_W-1:0] overvolt_q;
   logic [PMI_VAL_W-1:0] volt_set_q;
   logic [PMI_VAL_W-1:0] cur_lim_q;
   logic restart_q;
   logic protect_q;
   logic [4:0] rd_sel_q;
   logic [1:0] id_item_q;
   logic id_wen_q;
   logic [7:0] id_mem_q [MEM_N];

   logic [7:0] rx_byte;
   logic bcast;
   logic own;
   logic addr_ok;
   logic [7:0] tx_byte;
   logic [PMI_VAL_W-1:0] rd_val;
   logic [IW-1:0] rd_idx;
   logic [IW-1:0] wr_idx;
   logic [4:0] cmd_sel;
   logic [PMI_VAL_W-1:0] cmd_pay;

   assign rx_byte = {shreg_q[6:0], sda_i};
   // broadcast reads would have every module drive at once
   assign bcast = rx_byte[7:1] <= PMI_BCAST_LAST;
   assign own = rx_byte[7:1] == target_q[6:0];
   assign addr_ok = (own | bcast) & ~(bcast & rx_byte[0]);

   assign cmd_sel = cmd_word_q[PMI_SEL_HI:PMI_SEL_LO];
   assign cmd_pay = cmd_word_q[PMI_PAY_HI:PMI_PAY_LO];

   // ---------------------------------------------------------------
   // bus sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shreg_q <= 8'h00;
         tx_q <= 8'h00;
         byte_cnt_q <= 8'h00;
         rw_q <= 1'b0;
         pend_q <= 1'b0;
         sda_oe_q <= 1'b0;
         cmd_hi_q <= 8'h00;
         cmd_word_q <= 16'h0000;
         cmd_stb_q <= 1'b0;
         dat_q <= 8'h00;
         dat_idx_q <= 8'h00;
         dat_stb_q <= 1'b0;
      end
      else
      begin
         cmd_stb_q <= 1'b0;
         dat_stb_q <= 1'b0;
         if (start_det)
         begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 8'h00;
            pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
         end
         else if (stop_det)
         begin
            state_q <= ST_IDLE;
            pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  sda_oe_q <= 1'b0;
               end
               ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shreg_q <= rx_byte;
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == PMI_BIT_LAST)
                     begin
                        if (addr_ok)
                        begin
                           pend_q <= 1'b1;
                           rw_q <= rx_byte[0];
                        end
                        else
                        begin
                           state_q <= ST_IDLE;
                        end
                     end
                  end
                  else if (scl_fall && pend_q)
                  begin
                     pend_q <= 1'b0;
                     sda_oe_q <= 1'b1;
                     state_q <= ST_ACK;
                  end
               end
               ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shreg_q <= rx_byte;
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == PMI_BIT_LAST)
                     begin
                        pend_q <= 1'b1;
                        if (byte_cnt_q != PMI_BYTE_MAX)
                        begin
                           byte_cnt_q <= byte_cnt_q + 8'h01;
                        end
                        if (byte_cnt_q == 8'h00)
                        begin
                           cmd_hi_q <= rx_byte;
                        end
                        else if (byte_cnt_q == 8'h01)
                        begin
                           cmd_word_q <= {cmd_hi_q, rx_byte};
                           cmd_stb_q <= 1'b1;
                        end
                        else
                        begin
                           dat_q <= rx_byte;
                           dat_idx_q <= byte_cnt_q - 8'h01;
                           dat_stb_q <= 1'b1;
                        end
                     end
                  end
                  else if (scl_fall && pend_q)
                  begin
                     pend_q <= 1'b0;
                     sda_oe_q <= 1'b1;
                     state_q <= ST_ACK;
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_q <= 3'h0;
                     if (rw_q)
                     begin
                        tx_q <= tx_byte;
                        sda_oe_q <= ~tx_byte[7];
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RX;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_rise)
                  begin
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == PMI_BIT_LAST)
                     begin
                        pend_q <= 1'b1;
                     end
                  end
                  else if (scl_fall)
                  begin
                     if (pend_q)
                     begin
                        pend_q <= 1'b0;
                        sda_oe_q <= 1'b0;
                        state_q <= ST_MACK;
                        if (byte_cnt_q != PMI_BYTE_MAX)
                        begin
                           byte_cnt_q <= byte_cnt_q + 8'h01;
                        end
                     end
                     else
                     begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     if (sda_i)
                     begin
                        state_q <= ST_IDLE;
                     end
                     else
                     begin
                        pend_q <= 1'b1;
                     end
                  end
                  else if (scl_fall && pend_q)
                  begin
                     pend_q <= 1'b0;
                     bit_cnt_q <= 3'h0;
                     tx_q <= tx_byte;
                     sda_oe_q <= ~tx_byte[7];
                     state_q <= ST_TX;
                  end
               end
               default:
               begin
                  state_q <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // command execution
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         target_q <= TARGET_RST;
         overvolt_q <= PMI_SETTING_RST;
         volt_set_q <= PMI_SETTING_RST;
         cur_lim_q <= PMI_SETTING_RST;
         restart_q <= 1'b0;
         protect_q <= PMI_PROTECT_RST;
         rd_sel_q <= PMI_SEL_TYPE_ID;
         id_item_q <= 2'h0;
         id_wen_q <= 1'b0;
      end
      else
      begin
         restart_q <= 1'b0;
         if (cmd_stb_q)
         begin
            id_wen_q <= 1'b0;
            if (cmd_word_q[PMI_RD_BIT])
            begin
               rd_sel_q <= cmd_sel;
            end
            else
            begin
               case (cmd_sel)
                  PMI_SEL_TYPE_ID, PMI_SEL_SERIAL, PMI_SEL_CODE_VER, PMI_SEL_REVISION:
                  begin
                     id_item_q <= cmd_sel[1:0];
                     id_wen_q <= ~protect_q;
                  end
                  PMI_SEL_TARGET_ID:
                  begin
                     target_q <= cmd_pay;
                  end
                  PMI_SEL_OVERVOLT:
                  begin
                     overvolt_q <= cmd_pay;
                  end
                  PMI_SEL_VOLT_SET:
                  begin
                     volt_set_q <= cmd_pay;
                  end
                  PMI_SEL_CUR_LIM:
                  begin
                     cur_lim_q <= cmd_pay;
                  end
                  PMI_SEL_RESTART:
                  begin
                     restart_q <= 1'b1;
                  end
                  PMI_SEL_PROT_ON:
                  begin
                     protect_q <= 1'b1;
                  end
                  PMI_SEL_PROT_OFF:
                  begin
                     protect_q <= 1'b0;
                  end
                  default:
                  begin
                     id_wen_q <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // identity text storage
   // ---------------------------------------------------------------
   // byte 0 of an item rides in the payload, later bytes follow the command
   assign wr_idx = IW'(int'(id_item_q) * STR_LEN + int'(dat_idx_q));

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < MEM_N; i++)
         begin
            id_mem_q[i] <= PMI_ID_RST;
         end
      end
      else
      begin
         if (cmd_stb_q && !cmd_word_q[PMI_RD_BIT] && !protect_q
             && cmd_sel <= PMI_SEL_REVISION)
         begin
            id_mem_q[IW'(int'(cmd_sel[1:0]) * STR_LEN)] <= cmd_pay[7:0];
         end
         else if (dat_stb_q && id_wen_q && int'(dat_idx_q) < STR_LEN)
         begin
            id_mem_q[wr_idx] <= dat_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data selection
   // ---------------------------------------------------------------
   assign rd_idx = IW'(int'(rd_sel_q[1:0]) * STR_LEN + int'(byte_cnt_q));

   always_comb
   begin
      case (rd_sel_q)
         PMI_SEL_TARGET_ID: rd_val = target_q;
         PMI_SEL_OVERVOLT: rd_val = overvolt_q;
         PMI_SEL_VOLT_SET: rd_val = volt_set_q;
         PMI_SEL_CUR_LIM: rd_val = cur_lim_q;
         PMI_SEL_TEMP: rd_val = temperature_reading;
         PMI_SEL_OUT_VOLT: rd_val = output_volt_reading;
         PMI_SEL_CURR: rd_val = current_reading;
         default: rd_val = PMI_SETTING_RST;
      endcase
   end

   // bytes past the end of an answer read as released bus
   always_comb
   begin
      tx_byte = PMI_IDLE_BYTE;
      if (rd_sel_q <= PMI_SEL_REVISION)
      begin
         if (int'(byte_cnt_q) < STR_LEN)
         begin
            tx_byte = id_mem_q[rd_idx];
         end
      end
      else if (byte_cnt_q == 8'h00)
      begin
         tx_byte = {6'h00, rd_val[9:8]};
      end
      else if (byte_cnt_q == 8'h01)
      begin
         tx_byte = rd_val[7:0];
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sda_o <= 1'b0;
      end
      else
      begin
         sda_o <= 1'b0;
      end
   end

   assign sda_oe = sda_oe_q;
   assign bus_target_id = target_q;
   assign overvolt_trip_setting = overvolt_q;
   assign output_volt_setting = volt_set_q;
   assign current_limit_setting = cur_lim_q;
   assign soft_restart = restart_q;
   assign protect_on = protect_q;
endmodule

// file: pmi_pkg.sv
// constants, field layout and state type for the power module command slave
// assumes a single clock domain; shared by the slave and its edge helper
package pmi_pkg;

   // ---------------------------------------------------------------
   // command word layout
   // ---------------------------------------------------------------
   localparam int PMI_CMD_W = 16;
   localparam int PMI_VAL_W = 10;
   localparam int PMI_RD_BIT = 15;
   localparam int PMI_SEL_HI = 14;
   localparam int PMI_SEL_LO = 10;
   localparam int PMI_PAY_HI = 9;
   localparam int PMI_PAY_LO = 0;
   localparam int PMI_BYTE_W = 8;

   // ---------------------------------------------------------------
   // register select codes
   // ---------------------------------------------------------------
   localparam logic [4:0] PMI_SEL_TYPE_ID = 5'h00;
   localparam logic [4:0] PMI_SEL_SERIAL = 5'h01;
   localparam logic [4:0] PMI_SEL_CODE_VER = 5'h02;
   localparam logic [4:0] PMI_SEL_REVISION = 5'h03;
   localparam logic [4:0] PMI_SEL_TARGET_ID = 5'h04;
   localparam logic [4:0] PMI_SEL_OVERVOLT = 5'h05;
   localparam logic [4:0] PMI_SEL_VOLT_SET = 5'h06;
   localparam logic [4:0] PMI_SEL_CUR_LIM = 5'h07;
   localparam logic [4:0] PMI_SEL_TEMP = 5'h08;
   localparam logic [4:0] PMI_SEL_OUT_VOLT = 5'h09;
   localparam logic [4:0] PMI_SEL_CURR = 5'h0a;
   localparam logic [4:0] PMI_SEL_RESTART = 5'h0f;
   localparam logic [4:0] PMI_SEL_PROT_ON = 5'h10;
   localparam logic [4:0] PMI_SEL_PROT_OFF = 5'h11;

   // ---------------------------------------------------------------
   // bus constants and values after reset
   // ---------------------------------------------------------------
   localparam logic [6:0] PMI_BCAST_LAST = 7'h01;
   localparam logic [7:0] PMI_IDLE_BYTE = 8'hff;
   localparam logic [2:0] PMI_BIT_LAST = 3'h7;
   localparam logic [7:0] PMI_BYTE_MAX = 8'hff;
   localparam int PMI_STR_LEN_DEF = 8;
   localparam logic [9:0] PMI_TARGET_RST = 10'h020;
   localparam logic [9:0] PMI_SETTING_RST = 10'h000;
   localparam logic [7:0] PMI_ID_RST = 8'h00;
   localparam logic PMI_PROTECT_RST = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_MACK
   } pmi_state_t;

endpackage

// file: pmi_edge.sv
// sample register and edge strobes for one synchronous bus line
// assumes the line is already synchronous to ref_clk
`timescale 1ns/1ps
module pmi_edge
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic line_i,
   output logic prev_q,
   output logic rise,
   output logic fall
);
   import pmi_pkg::*;

   // released bus idles high, so reset to high avoids a false edge
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prev_q <= 1'b1;
      end
      else
      begin
         prev_q <= line_i;
      end
   end

   assign rise = line_i & ~prev_q;
   assign fall = ~line_i & prev_q;
endmodule

// file: pmi_cmd_slave_asserts.sv
// port assertions for the command slave
// assumes one clock domain; bound to every slave instance below
`timescale 1ns/1ps
module pmi_cmd_slave_chk
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic [9:0] bus_target_id,
   input wire logic [9:0] output_volt_setting,
   input wire logic soft_restart,
   input wire logic protect_on
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_open_drain: assert property (!sda_o)
      else $error("data output driven high");
   a_oe_rise_edge: assert property ($rose(sda_oe) |-> !$past(scl_i) && $past(scl_i, 2))
      else $error("data enable rose away from clock fall");
   a_oe_fall_edge: assert property ($fell(sda_oe) |-> !$past(scl_i) && $past(scl_i, 2))
      else $error("data enable fell away from clock fall");
   a_oe_high_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data enable moved while clock high");
   a_restart_pulse: assert property (soft_restart |=> !soft_restart)
      else $error("restart pulse too long");
   a_restart_moment: assert property (soft_restart |-> !sda_oe && $past(scl_i))
      else $error("restart pulse out of place");
   a_setting_moment: assert property ($changed(output_volt_setting) |-> !sda_oe && $past(scl_i))
      else $error("setting changed out of place");
   a_target_moment: assert property ($changed(bus_target_id) |-> !sda_oe && $past(scl_i))
      else $error("bus address changed out of place");
   a_protect_moment: assert property ($changed(protect_on) |-> !sda_oe && $past(scl_i))
      else $error("protect changed out of place");
endmodule

bind pmi_cmd_slave pmi_cmd_slave_chk u_pmi_cmd_slave_chk
(
   .ref_clk(ref_clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .bus_target_id(bus_target_id), .output_volt_setting(output_volt_setting),
   .soft_restart(soft_restart), .protect_on(protect_on)
);

// file: pmi_bus_master.sv
// behavioural two-wire bus controller; data line has a pull-up
// assumes the bench calls its tasks; each byte result is strobed out
`timescale 1ns/1ps
module pmi_bus_master
(
   input wire logic ref_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda,
   output logic [7:0] res_val,
   output logic res_stb
);
   logic pull_low = 1'b0;
   // released line floats back high through the pull-up
   assign sda = !(pull_low || sda_oe);
   initial
   begin
      scl = 1'b1;
      res_val = 8'h00;
      res_stb = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // data moves only while the clock line is low
   task automatic slot(input logic b, output logic r);
      wait_clk(2);
      pull_low <= !b;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(2);
      r = sda;
      wait_clk(2);
      scl <= 1'b0;
   endtask
   task automatic start();
      wait_clk(4);
      pull_low <= 1'b1;
      wait_clk(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      wait_clk(2);
      pull_low <= 1'b1;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(4);
      pull_low <= 1'b0;
   endtask
   task automatic report(input logic [7:0] v);
      res_val <= v;
      res_stb <= 1'b1;
      wait_clk(1);
      res_stb <= 1'b0;
   endtask
   // result is 1 when the slave acknowledged
   task automatic wbyte(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
         slot(v[i], r);
      slot(1'b1, r);
      report({7'h00, !r});
   endtask
   task automatic rbyte(input logic ack);
      logic [7:0] v;
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         slot(1'b1, r);
         v[i] = r;
      end
      slot(!ack, r);
      report(v);
   endtask
endmodule

// file: test_pmi_cmd_slave.sv
// self-checking bench for the command slave, driven by the bus master model
// assumes package, slave, checker and master model are compiled first
`timescale 1ns/1ps
module test_pmi_cmd_slave;
   import pmi_pkg::*;
   localparam logic [6:0] ADR = PMI_TARGET_RST[6:0];
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda, sda_o, sda_oe, soft_restart, protect_on, res_stb;
   logic [9:0] tgt, ovp, vset, cur_lim;
   logic [9:0] temp = 10'h000, volt_rd = 10'h000, curr = 10'h000;
   logic [7:0] res_val;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hde94_284d;
   int miscompares = 0, checked = 0, restarts = 0;
   initial
   begin
      forever #12.5 ref_clk = !ref_clk;
   end
   pmi_cmd_slave #(.STR_LEN(4)) u_pmi_cmd_slave
   (
      .ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .bus_target_id(tgt), .overvolt_trip_setting(ovp),
      .output_volt_setting(vset), .current_limit_setting(cur_lim),
      .temperature_reading(temp), .output_volt_reading(volt_rd), .current_reading(curr),
      .soft_restart(soft_restart), .protect_on(protect_on)
   );
   pmi_bus_master u_pmi_bus_master
   (
      .ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
      .res_val(res_val), .res_stb(res_stb)
   );
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   always @(posedge ref_clk)
      if (res_stb === 1'b1)
         cmp("bus byte", {2'b00, exp_q.pop_front()}, {2'b00, res_val});
   always @(posedge ref_clk)
      if (soft_restart === 1'b1)
         restarts++;
   task automatic wb(input logic [7:0] b, input logic k);
      exp_q.push_back({7'h00, k});
      u_pmi_bus_master.wbyte(b);
   endtask
   // command write left open so data bytes may follow
   task automatic cmd_open(input logic [6:0] a, input logic [15:0] w, input logic k);
      u_pmi_bus_master.start();
      wb({a, 1'b0}, k);
      wb(w[15:8], k);
      wb(w[7:0], k);
   endtask
   task automatic cmd(input logic [6:0] a, input logic [15:0] w, input logic k);
      cmd_open(a, w, k);
      u_pmi_bus_master.stop();
   endtask
   task automatic rd(input logic [6:0] a, input logic [4:0] s, input logic k,
                     input logic [7:0] e[$]);
      cmd(a, {1'b1, s, 10'h000}, 1'b1);
      u_pmi_bus_master.start();
      wb({a, 1'b1}, k);
      foreach (e[i])
      begin
         exp_q.push_back(e[i]);
         u_pmi_bus_master.rbyte(1'b1);
      end
      u_pmi_bus_master.stop();
   endtask
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      give_verdict();
   end
   initial
   begin
      logic [9:0] v[3];
      logic [9:0] m[3];
      logic [7:0] b[4];
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp("target reset", PMI_TARGET_RST, tgt);
      cmp("protect reset", 10'h001, {9'h000, protect_on});
      for (int i = 0; i < 3; i++)
      begin
         v[i] = 10'(xs());
         cmd(ADR, {1'b0, 5'(5 + i), v[i]}, 1'b1);
         rd(ADR, 5'(5 + i), 1'b1, '{{6'h00, v[i][9:8]}, v[i][7:0], 8'hff});
      end
      temp <= 10'(xs());
      volt_rd <= 10'(xs());
      curr <= 10'(xs());
      @(posedge ref_clk);
      m = '{temp, volt_rd, curr};
      for (int i = 0; i < 3; i++)
         rd(ADR, 5'(8 + i), 1'b1, '{{6'h00, m[i][9:8]}, m[i][7:0]});
      cmd(ADR, {1'b0, PMI_SEL_TEMP, 10'h3ff}, 1'b1);
      cmd(ADR, {1'b0, 5'h0c, 10'h3ff}, 1'b1);
      cmd(7'h33, {1'b0, PMI_SEL_OVERVOLT, 10'h3ff}, 1'b0);
      cmp("overvolt", v[0], ovp);
      cmp("volt set", v[1], vset);
      cmp("current limit", v[2], cur_lim);
      cmd(7'h00, {1'b0, PMI_SEL_OVERVOLT, 10'h155}, 1'b1);
      cmp("broadcast write", 10'h155, ovp);
      rd(7'h01, PMI_SEL_OVERVOLT, 1'b0, '{8'hff});
      rd(ADR, PMI_SEL_RESTART, 1'b1, '{8'h00, 8'h00});
      cmd(ADR, {1'b0, PMI_SEL_RESTART, 10'h000}, 1'b1);
      cmp("restart pulses", 10'h001, 10'(restarts));
      cmd(ADR, {1'b0, PMI_SEL_PROT_OFF, 10'h000}, 1'b1);
      cmp("unprotect", 10'h000, {9'h000, protect_on});
      foreach (b[i])
         b[i] = 8'(xs());
      cmd_open(ADR, {1'b0, PMI_SEL_SERIAL, 2'b00, b[0]}, 1'b1);
      for (int i = 1; i < 4; i++)
         wb(b[i], 1'b1);
      u_pmi_bus_master.stop();
      rd(ADR, PMI_SEL_SERIAL, 1'b1, '{b[0], b[1], b[2], b[3], 8'hff});
      rd(ADR, PMI_SEL_TYPE_ID, 1'b1, '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff});
      cmd(ADR, {1'b0, PMI_SEL_PROT_ON, 10'h000}, 1'b1);
      cmp("protect", 10'h001, {9'h000, protect_on});
      cmd(ADR, {1'b0, PMI_SEL_SERIAL, 2'b00, ~b[0]}, 1'b1);
      rd(ADR, PMI_SEL_SERIAL, 1'b1, '{b[0], b[1], b[2], b[3]});
      cmd(ADR, {1'b0, PMI_SEL_TARGET_ID, 10'h015}, 1'b1);
      cmp("new target", 10'h015, tgt);
      cmd(ADR, {1'b0, PMI_SEL_VOLT_SET, 10'h000}, 1'b0);
      rd(7'h15, PMI_SEL_TARGET_ID, 1'b1, '{8'h00, 8'h15});
      repeat (4) @(posedge ref_clk);
      cmp("bytes left", 10'h000, 10'(exp_q.size()));
      give_verdict();
   end
endmodule
